// file: mic_pkg.sv
// Constants and carrier types for the interrupt controller
package mic_pkg;
  // Register port and program counter widths
  localparam int AW = 8;
  localparam int DW = 8;
  localparam int PCW = 13;

  // Register offsets on the plain register port
  localparam logic [7:0] OFS_OPTION = 8'h81;
  localparam logic [7:0] OFS_ICTL = 8'h0B;
  localparam logic [7:0] OFS_PFLAG = 8'h0C;
  localparam logic [7:0] OFS_PEN = 8'h8C;
  localparam logic [7:0] OFS_ISTAT = 8'h90;
  localparam logic [7:0] OFS_IMASK = 8'h91;

  // Reset values
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam logic [7:0] RST_ICTL = 8'h00;
  localparam logic [7:0] RST_PFLAG = 8'h00;
  localparam logic [7:0] RST_PEN = 8'h00;
  localparam logic [7:0] RST_ISTAT = 8'h00;
  localparam logic [7:0] RST_IMASK = 8'h00;

  // Field positions in interrupt_control
  localparam int B_GIE = 7;
  localparam int B_PEIE = 6;
  localparam int B_TIMER_OVERFLOW_ENABLE = 5;
  localparam int B_EXT_PIN_ENABLE = 4;
  localparam int B_PORT_CHANGE_ENABLE = 3;
  localparam int B_TIMER_OVERFLOW_FLAG = 2;
  localparam int B_EXT_PIN_FLAG = 1;
  localparam int B_PORT_CHANGE_FLAG = 0;
  // Edge select in option_config, converter bit in flags/enables
  localparam int B_EDGE = 6;
  localparam int B_ADC = 0;
  // Sticky status bits
  localparam int S_ACC = 0;
  localparam int S_WAKE = 1;
  localparam int S_RET = 2;
  localparam int NSTAT = 3;

  // Vector, timing and synchronised pin count
  localparam logic [PCW-1:0] VEC_ADDR = 13'h0004;
  localparam int CLKS_PER_INSTR = 4;
  localparam int NPINS = 4;

  // Core events into the controller
  typedef struct packed {
    logic timer_ovf;
    logic conv_done;
    logic return_from_irq_instr;
    logic asleep;
  } mic_core_evt_t;

  // Commands to the core sequencer
  typedef struct packed {
    logic push;
    logic load_pc;
    logic pop;
    logic wake;
    logic [PCW-1:0] ret_addr;
    logic [PCW-1:0] vec_addr;
  } mic_core_cmd_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_ENTER = 2'b01
  } mic_state_t;
endpackage : mic_pkg

// file: mic_irq_ctrl.sv
// Interrupt controller of the small microcontroller core
`timescale 1ns/100ps
module mic_irq_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [mic_pkg::AW-1:0] reg_addr,
  input wire logic [mic_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [mic_pkg::DW-1:0] reg_rdata,
  // Core sequencer
  input wire mic_pkg::mic_core_evt_t core_evt,
  input wire logic [mic_pkg::PCW-1:0] pc_now,
  output mic_pkg::mic_core_cmd_t core_cmd,
  // Pins
  input wire logic ext_irq_pin,
  input wire logic port_pin_zero,
  input wire logic port_pin_one,
  input wire logic port_pin_three,
  // Interrupt to system
  output logic irq_out
);
  logic [7:0] option_config_r;
  logic [7:0] interrupt_control_r;
  logic [7:0] peripheral_flags_r;
  logic [7:0] peripheral_enables_r;
  logic [mic_pkg::NSTAT-1:0] istat_r;
  logic [mic_pkg::NSTAT-1:0] imask_r;
  logic [1:0] q_r;
  mic_pkg::mic_state_t state_r;
  logic [mic_pkg::NPINS-1:0] sync1_r;
  logic [mic_pkg::NPINS-1:0] sync2_r;
  logic [mic_pkg::NPINS-1:0] sync3_r;
  logic [mic_pkg::NPINS-1:0] lvl_r;
  logic [mic_pkg::NPINS-1:0] lvl_nxt;
  logic [mic_pkg::NPINS-1:0] agree;
  logic prime_r;
  logic [1:0] fill_r;
  logic wake_cond_r;
  logic instr_tick;
  logic ext_edge;
  logic port_chg;
  logic [3:0] pend;
  logic any_pend;
  logic accept;
  logic wake_cond;
  logic global_irq_enable;
  logic wr_ictl;
  logic wr_pflag;
  logic [mic_pkg::NSTAT-1:0] stat_set;
  logic [mic_pkg::NSTAT-1:0] stat_clr;

  assign global_irq_enable = interrupt_control_r[mic_pkg::B_GIE];
  assign wr_ictl = reg_wr && (reg_addr == mic_pkg::OFS_ICTL);
  assign wr_pflag = reg_wr && (reg_addr == mic_pkg::OFS_PFLAG);

  // Instruction cycle phase; requests are taken on its last clock
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= 2'h0;
    end else begin
      q_r <= q_r + 2'h1;
    end
  end
  assign instr_tick = (q_r == 2'(mic_pkg::CLKS_PER_INSTR - 1));

  // Three-stage pin synchronisers: ext, pin three, pin one, pin zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      sync3_r <= 4'h0;
    end else begin
      sync1_r <= {ext_irq_pin, port_pin_three, port_pin_one,
                  port_pin_zero};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // A level counts once the second and third stage agree
  assign agree = ~(sync2_r ^ sync3_r);
  assign lvl_nxt = (agree & sync2_r) | (~agree & lvl_r);

  // Latched levels; edges count only once all stages hold real pin
  // levels, so a pin that idles high makes no false edge after reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_r <= 4'h0;
      fill_r <= 2'h0;
      prime_r <= 1'b0;
    end else begin
      lvl_r <= lvl_nxt;
      if (fill_r != 2'h3) begin
        fill_r <= fill_r + 2'h1;
      end
      if ((fill_r == 2'h3) && (&agree)) begin
        prime_r <= 1'b1;
      end
    end
  end

  // Edge on the external pin, polarity from option_config
  always_comb begin
    ext_edge = 1'b0;
    if (prime_r && (lvl_nxt[3] != lvl_r[3])) begin
      ext_edge = (lvl_nxt[3] == option_config_r[mic_pkg::B_EDGE]);
    end
  end
  // Any mismatch on the three watched pins
  assign port_chg = prime_r && (lvl_nxt[2:0] != lvl_r[2:0]);

  // Pending requests, one per source
  always_comb begin
    pend[3] = interrupt_control_r[mic_pkg::B_TIMER_OVERFLOW_FLAG]
              && interrupt_control_r[mic_pkg::B_TIMER_OVERFLOW_ENABLE];
    pend[2] = interrupt_control_r[mic_pkg::B_EXT_PIN_FLAG]
              && interrupt_control_r[mic_pkg::B_EXT_PIN_ENABLE];
    pend[1] = interrupt_control_r[mic_pkg::B_PORT_CHANGE_FLAG]
              && interrupt_control_r[mic_pkg::B_PORT_CHANGE_ENABLE];
    pend[0] = interrupt_control_r[mic_pkg::B_PEIE]
              && peripheral_enables_r[mic_pkg::B_ADC]
              && peripheral_flags_r[mic_pkg::B_ADC];
  end
  assign any_pend = |pend;

  // Taken at an instruction boundary; the core's own instruction
  // length plays no part, so latency does not depend on it
  assign accept = (state_r == mic_pkg::ST_RUN) && instr_tick && global_irq_enable
                  && any_pend && !core_evt.asleep;

  // Sleep wake-up ignores the global enable
  assign wake_cond = core_evt.asleep && any_pend;

  // Entry sequencer: one cycle of push and load per acceptance
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= mic_pkg::ST_RUN;
    end else begin
      case (state_r)
        mic_pkg::ST_RUN: begin
          if (accept) begin
            state_r <= mic_pkg::ST_ENTER;
          end
        end
        mic_pkg::ST_ENTER: begin
          state_r <= mic_pkg::ST_RUN;
        end
        default: begin
          state_r <= mic_pkg::ST_RUN;
        end
      endcase
    end
  end

  // Command to the core; the return address and the vector are latched on acceptance
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_cmd <= '0;
      wake_cond_r <= 1'b0;
    end else begin
      core_cmd.push <= accept;
      core_cmd.load_pc <= accept;
      core_cmd.pop <= core_evt.return_from_irq_instr;
      core_cmd.wake <= wake_cond && !wake_cond_r;
      wake_cond_r <= wake_cond;
      if (accept) begin
        core_cmd.ret_addr <= pc_now;
        core_cmd.vec_addr <= mic_pkg::VEC_ADDR;
      end
    end
  end

  // Control register; hardware flag sets win over a software clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_control_r <= mic_pkg::RST_ICTL;
    end else begin
      if (wr_ictl) begin
        interrupt_control_r <= reg_wdata;
      end
      if (core_evt.return_from_irq_instr) begin
        interrupt_control_r[mic_pkg::B_GIE] <= 1'b1;
      end
      if (accept) begin
        interrupt_control_r[mic_pkg::B_GIE] <= 1'b0;
      end
      if (core_evt.timer_ovf) begin
        interrupt_control_r[mic_pkg::B_TIMER_OVERFLOW_FLAG] <= 1'b1;
      end
      if (ext_edge) begin
        interrupt_control_r[mic_pkg::B_EXT_PIN_FLAG] <= 1'b1;
      end
      if (port_chg) begin
        interrupt_control_r[mic_pkg::B_PORT_CHANGE_FLAG] <= 1'b1;
      end
    end
  end

  // Peripheral flag register; converter done wins over a clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      peripheral_flags_r <= mic_pkg::RST_PFLAG;
    end else begin
      if (wr_pflag) begin
        peripheral_flags_r <= reg_wdata;
      end
      if (core_evt.conv_done) begin
        peripheral_flags_r[mic_pkg::B_ADC] <= 1'b1;
      end
    end
  end

  // Plain software registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      option_config_r <= mic_pkg::RST_OPTION;
      peripheral_enables_r <= mic_pkg::RST_PEN;
      imask_r <= mic_pkg::NSTAT'(mic_pkg::RST_IMASK);
    end else if (reg_wr) begin
      case (reg_addr)
        mic_pkg::OFS_OPTION: option_config_r <= reg_wdata;
        mic_pkg::OFS_PEN: peripheral_enables_r <= reg_wdata;
        mic_pkg::OFS_IMASK: imask_r <= reg_wdata[mic_pkg::NSTAT-1:0];
        default: ;
      endcase
    end
  end

  // Sticky status: write one to clear, a new event wins
  assign stat_set = {core_evt.return_from_irq_instr, wake_cond && !wake_cond_r, accept};
  assign stat_clr = (reg_wr && reg_addr == mic_pkg::OFS_ISTAT)
                    ? reg_wdata[mic_pkg::NSTAT-1:0] : 3'h0;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      istat_r <= mic_pkg::NSTAT'(mic_pkg::RST_ISTAT);
    end else begin
      istat_r <= (istat_r & ~stat_clr) | stat_set;
    end
  end
  assign irq_out = |(istat_r & imask_r);

  // Read data only in the cycle after the read strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        mic_pkg::OFS_OPTION: reg_rdata <= option_config_r;
        mic_pkg::OFS_ICTL: reg_rdata <= interrupt_control_r;
        mic_pkg::OFS_PFLAG: reg_rdata <= peripheral_flags_r;
        mic_pkg::OFS_PEN: reg_rdata <= peripheral_enables_r;
        mic_pkg::OFS_ISTAT: reg_rdata <= {5'h00, istat_r};
        mic_pkg::OFS_IMASK: reg_rdata <= {5'h00, imask_r};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Checks on the controller's own behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  gie_clear_a: assert property (accept |=> !global_irq_enable)
    else $error("global enable not cleared on entry");
  vector_load_a: assert property (
      accept |=> core_cmd.load_pc && core_cmd.push
      && core_cmd.vec_addr == mic_pkg::VEC_ADDR)
    else $error("entry did not load vector 0004h");
  return_from_irq_instr_sets_a: assert property (
      core_evt.return_from_irq_instr && !accept |=> global_irq_enable && core_cmd.pop)
    else $error("return did not restore global enable");
  gie_blocks_a: assert property (!global_irq_enable |-> !accept)
    else $error("request taken with global enable clear");
  timer_flag_a: assert property (
      core_evt.timer_ovf |=> interrupt_control_r[mic_pkg::B_TIMER_OVERFLOW_FLAG])
    else $error("timer flag not set on overflow");
  ext_flag_a: assert property (
      ext_edge |=> interrupt_control_r[mic_pkg::B_EXT_PIN_FLAG])
    else $error("external flag not set on edge");
  port_flag_a: assert property (
      port_chg |=> interrupt_control_r[mic_pkg::B_PORT_CHANGE_FLAG])
    else $error("port change flag not set");
  vector_now_a: assert property (
      global_irq_enable && any_pend && !core_evt.asleep && state_r == mic_pkg::ST_RUN
      && !reg_wr && !core_evt.return_from_irq_instr |-> ##[0:3] accept)
    else $error("pending request not taken within one instruction");
  wake_pulse_a: assert property (
      $rose(wake_cond) |=> core_cmd.wake ##1 !core_cmd.wake)
    else $error("wake pulse missing or too long");
  conv_gate_a: assert property (
      !interrupt_control_r[mic_pkg::B_PEIE] && pend[3:1] == 3'h0
      |-> !accept)
    else $error("converter taken without group enable");
  conv_flag_a: assert property (
      core_evt.conv_done |=> peripheral_flags_r[mic_pkg::B_ADC])
    else $error("converter flag not set on completion");
  ret_addr_a: assert property (
      accept |=> core_cmd.ret_addr == $past(pc_now))
    else $error("return address not taken from the program counter");
  sleep_hold_a: assert property (core_evt.asleep |-> !accept)
    else $error("request taken while asleep");
  entry_once_a: assert property (
      core_cmd.push |=> !core_cmd.push && !core_cmd.load_pc)
    else $error("entry command longer than one cycle");
  pop_pulse_a: assert property (core_evt.return_from_irq_instr |=> core_cmd.pop)
    else $error("return did not pop the return address");
  conv_enable_a: assert property (
      accept && pend[3:1] == 3'h0 |-> peripheral_enables_r[mic_pkg::B_ADC]
      && interrupt_control_r[mic_pkg::B_PEIE])
    else $error("converter taken without its enables");

  // Main scenarios: entry, wake, return, converter and port requests
  entry_c: cover property (accept ##1 core_cmd.load_pc);
  wake_c: cover property (core_cmd.wake);
  return_c: cover property (accept ##[1:40] core_evt.return_from_irq_instr);
  conv_c: cover property (accept && pend == 4'h1);
  port_c: cover property (accept && pend == 4'h2);
endmodule : mic_irq_ctrl

// file: mic_core_model.sv
// Core sequencer and peripheral sources facing the interrupt controller
`timescale 1ns/100ps
module mic_core_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Bench requests
  input wire logic tmr_go,
  input wire logic conv_req,
  input wire logic ret_req,
  input wire logic sleep_req,
  // Controller link
  input wire mic_pkg::mic_core_cmd_t core_cmd,
  output mic_pkg::mic_core_evt_t core_evt,
  output logic [mic_pkg::PCW-1:0] pc_now
);
  logic [7:0] tmr_r;
  logic [mic_pkg::PCW-1:0] stack_r;

  // Timer rolls over FFh to 00h and pulses the event once
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_r <= 8'h00;
      core_evt <= '0;
    end else begin
      if (tmr_go) tmr_r <= tmr_r + 8'h01;
      core_evt.timer_ovf <= tmr_go && (tmr_r == 8'hFF);
      core_evt.conv_done <= conv_req;
      core_evt.return_from_irq_instr <= ret_req;
      core_evt.asleep <= sleep_req;
    end
  end

  // Program counter stalls in sleep so wake timing stays visible
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_now <= 13'h0100;
      stack_r <= 13'h0000;
    end else begin
      if (core_cmd.load_pc) pc_now <= core_cmd.vec_addr;
      else if (core_cmd.pop) pc_now <= stack_r;
      else if (!core_evt.asleep) pc_now <= pc_now + 13'h0001;
      if (core_cmd.push) stack_r <= core_cmd.ret_addr;
    end
  end
endmodule : mic_core_model

// file: mic_irq_ctrl_tb_top.sv
// Self-checking bench of the interrupt controller
`timescale 1ns/100ps
`define CHK(nm, e, g) cmp(nm, 32'(e), 32'(g))
module mic_irq_ctrl_tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic irq_out;
  logic ext_irq_pin = 1'b0;
  logic [2:0] pp = 3'h0;
  logic tmr_go = 1'b0;
  logic conv_req = 1'b0;
  logic ret_req = 1'b0;
  logic sleep_req = 1'b0;
  mic_pkg::mic_core_evt_t core_evt;
  mic_pkg::mic_core_cmd_t core_cmd;
  logic [mic_pkg::PCW-1:0] pc_now;
  logic [3:0] cbits;
  logic [7:0] d;
  logic [7:0] a;
  logic want;
  int fail_count = 0;
  int check_count = 0;
  int push_cnt = 0;
  int n;

  mic_irq_ctrl mic_irq_ctrl_i (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_evt(core_evt),
    .pc_now(pc_now), .core_cmd(core_cmd), .ext_irq_pin(ext_irq_pin),
    .port_pin_zero(pp[0]), .port_pin_one(pp[1]),
    .port_pin_three(pp[2]), .irq_out(irq_out));
  mic_core_model mic_core_model_i (.core_clk(core_clk), .rst_n(rst_n),
    .tmr_go(tmr_go), .conv_req(conv_req), .ret_req(ret_req),
    .sleep_req(sleep_req), .core_cmd(core_cmd), .core_evt(core_evt),
    .pc_now(pc_now));

  // Command pulses packed for polling by index
  assign cbits = {core_cmd.push, core_cmd.load_pc, core_cmd.pop,
    core_cmd.wake};
  always @(posedge core_clk) if (cbits[3] === 1'b1) push_cnt++;

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  task give_verdict;
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask : cmp

  // External flag expected after the pin moves from was to now_lvl
  function automatic logic exp_ext(input logic rise, input logic was,
                                   input logic now_lvl);
    return (was != now_lvl) && (now_lvl == rise);
  endfunction : exp_ext

  // Pin move to push: three sync stages, flag, then 1..4 to a boundary
  function automatic logic lat_ok(input int cnt);
    return cnt >= 5 && cnt <= 4 + mic_pkg::CLKS_PER_INSTR;
  endfunction : lat_ok

  task cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask : cyc

  task wr(input logic [7:0] ad, input logic [7:0] w);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= w;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task rd(input logic [7:0] ad, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  // Bounded poll for a one-cycle command pulse
  task wait_cmd(input int sel, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge core_clk);
      #1 cnt++;
    end while (cnt < lim && cbits[sel] !== 1'b1);
  endtask : wait_cmd

  task pulse_pin;
    @(posedge core_clk);
    ext_irq_pin <= ~ext_irq_pin;
  endtask : pulse_pin

  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h3112));
    cyc(4);
    rst_n <= 1'b1;
    cyc(8);
    rd(mic_pkg::OFS_OPTION, d);
    `CHK("option reset", mic_pkg::RST_OPTION, d);
    rd(mic_pkg::OFS_ICTL, d);
    `CHK("ictl reset", mic_pkg::RST_ICTL, d);
    // Unmapped space ignores writes and reads zero
    repeat (3) begin
      a = 8'hA0 + 8'($urandom_range(0, 15));
      wr(a, 8'($urandom));
      rd(a, d);
      `CHK("unmapped", 8'h00, d);
    end
    // Edge select: rise, fall under rising; rise, fall under falling
    for (int i = 0; i < 4; i++) begin
      wr(mic_pkg::OFS_OPTION, (i < 2) ? 8'hFF : 8'hBF);
      wr(mic_pkg::OFS_ICTL, 8'h00);
      cyc($urandom_range(0, 3));
      want = exp_ext(i < 2, ext_irq_pin, ~ext_irq_pin);
      pulse_pin();
      cyc(8);
      rd(mic_pkg::OFS_ICTL, d);
      `CHK("ext flag", want, d[mic_pkg::B_EXT_PIN_FLAG]);
    end
    for (int i = 0; i < 3; i++) begin
      wr(mic_pkg::OFS_ICTL, 8'h00);
      @(posedge core_clk) pp[i] <= ~pp[i];
      cyc(8);
      rd(mic_pkg::OFS_ICTL, d);
      `CHK("port flag", 1'b1, d[mic_pkg::B_PORT_CHANGE_FLAG]);
    end
    // Timer flag rises only at rollover, global enable still clear
    wr(mic_pkg::OFS_ICTL, 8'h20);
    @(posedge core_clk) tmr_go <= 1'b1;
    cyc(240);
    rd(mic_pkg::OFS_ICTL, d);
    `CHK("timer early", 1'b0, d[mic_pkg::B_TIMER_OVERFLOW_FLAG]);
    cyc(16);
    rd(mic_pkg::OFS_ICTL, d);
    `CHK("timer flag", 1'b1, d[mic_pkg::B_TIMER_OVERFLOW_FLAG]);
    @(posedge core_clk) tmr_go <= 1'b0;
    `CHK("gie blocks", 0, push_cnt);
    // Converter needs its enable and the group enable
    wr(mic_pkg::OFS_ICTL, 8'h00);
    @(posedge core_clk) conv_req <= 1'b1;
    @(posedge core_clk) conv_req <= 1'b0;
    cyc(2);
    rd(mic_pkg::OFS_PFLAG, d);
    `CHK("conv flag", 8'h01, d);
    wr(mic_pkg::OFS_PEN, 8'h01);
    wr(mic_pkg::OFS_ICTL, 8'h80);
    cyc(12);
    `CHK("peie gate", 0, push_cnt);
    wr(mic_pkg::OFS_ICTL, 8'hC0);
    wait_cmd(3, 12, n);
    `CHK("push", 1'b1, core_cmd.push);
    `CHK("load pc", 1'b1, core_cmd.load_pc);
    `CHK("vector", mic_pkg::VEC_ADDR, core_cmd.vec_addr);
    `CHK("ret addr", pc_now - 13'h0001, core_cmd.ret_addr);
    rd(mic_pkg::OFS_ICTL, d);
    `CHK("gie cleared", 1'b0, d[mic_pkg::B_GIE]);
    // Sticky status bit, mask and level output
    rd(mic_pkg::OFS_ISTAT, d);
    `CHK("status", 8'h01, d);
    `CHK("irq masked", 1'b0, irq_out);
    wr(mic_pkg::OFS_IMASK, 8'h01);
    #1 `CHK("irq on", 1'b1, irq_out);
    wr(mic_pkg::OFS_ISTAT, 8'h01);
    #1 `CHK("irq cleared", 1'b0, irq_out);
    // Service routine clears its flag before returning
    wr(mic_pkg::OFS_PFLAG, 8'h00);
    @(posedge core_clk) ret_req <= 1'b1;
    @(posedge core_clk) ret_req <= 1'b0;
    wait_cmd(1, 8, n);
    `CHK("pop", 1'b1, core_cmd.pop);
    rd(mic_pkg::OFS_ICTL, d);
    `CHK("gie set", 1'b1, d[mic_pkg::B_GIE]);
    cyc(12);
    `CHK("no reentry", 1, push_cnt);
    // Latency from a rising pin edge to the vector
    wr(mic_pkg::OFS_OPTION, 8'hFF);
    wr(mic_pkg::OFS_ICTL, 8'h90);
    pulse_pin();
    wait_cmd(3, 16, n);
    `CHK("latency", 1'b1, lat_ok(n));
    // Falling edge in sleep wakes without vectoring
    wr(mic_pkg::OFS_OPTION, 8'hBF);
    wr(mic_pkg::OFS_ICTL, 8'h10);
    @(posedge core_clk) sleep_req <= 1'b1;
    cyc(4);
    pulse_pin();
    wait_cmd(0, 16, n);
    `CHK("wake", 1'b1, core_cmd.wake);
    rd(mic_pkg::OFS_ISTAT, d);
    `CHK("wake status", 1'b1, d[mic_pkg::S_WAKE]);
    wr(mic_pkg::OFS_ICTL, 8'h92);
    cyc(8);
    `CHK("asleep hold", 2, push_cnt);
    @(posedge core_clk) sleep_req <= 1'b0;
    wait_cmd(3, 16, n);
    `CHK("vector awake", 1'b1, core_cmd.push);
    // Port change vectors as well with its enable and the global enable
    wr(mic_pkg::OFS_ICTL, 8'h88);
    @(posedge core_clk) pp[0] <= ~pp[0];
    wait_cmd(3, 16, n);
    `CHK("port vector", 1'b1, core_cmd.push);
    // Reset in mid-run: global enable clear, high pins make no edge
    wr(mic_pkg::OFS_ICTL, 8'h80);
    @(posedge core_clk) rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(4);
    rd(mic_pkg::OFS_ICTL, d);
    `CHK("ictl mid reset", mic_pkg::RST_ICTL, d);
    give_verdict();
  end
endmodule : mic_irq_ctrl_tb_top
